//--- dv/smcg_peer.sv
// Far-side model: SPI slave plus a rival master on the enable pin
`timescale 1ns/1ns
module smcg_peer (
    // Serial pins from the master
    input wire logic sclk_in,
    input wire logic sclk_oe_in,
    input wire logic mosi_in,
    input wire logic mosi_oe_in,
    // Enable pin drive from the master
    input wire logic ste_drv_in,
    input wire logic ste_dir_in,
    // Bench control: rival master owns the bus
    input wire logic rival_in,
    // Lines back to the master
    output logic miso_out,
    output logic ste_line_out,
    output logic [7:0] rx_out
);
    localparam logic [7:0] REPLY = 8'hc3;  // Answer byte on every word
    logic [2:0] cnt_q = 3'h0;  // Bit position within the word
    logic [7:0] rx_q = 8'h00;  // Last eight bits seen on the data line
    // Pin level: master drives it, else the rival holds it
    assign ste_line_out = ste_dir_in ? ste_drv_in : !rival_in;
    // Shift in on rising clock; a released bus restarts the word
    always @(posedge sclk_in or negedge sclk_oe_in) begin
        if (!sclk_oe_in) begin
            cnt_q <= 3'h0;
        end else if (mosi_oe_in) begin
            rx_q <= {rx_q[6:0], mosi_in};
            cnt_q <= cnt_q + 3'h1;
        end
    end
    // Reply goes out MSB first, changing after each rising edge
    assign miso_out = REPLY[3'h7 - cnt_q];
    assign rx_out = rx_q;
endmodule

//--- dv/smcg_top_test.sv
// Register-level tests of the conflict-guarded SPI master
`timescale 1ns/1ns
module smcg_top_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;  // Active low reset
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sclk, sclk_oe, mosi, mosi_oe, miso;
    logic ste_line, ste_drv, ste_oe, irq;
    logic rival = 1'b0;  // Rival master holds the bus
    logic ce = 1'b1;  // Clock enable to the block
    logic [7:0] rx;
    logic [31:0] q;
    logic e;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    smcg_top dut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .SCLK_OUT(sclk), .SCLK_OE_OUT(sclk_oe),
        .MOSI_OUT(mosi), .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso),
        .STE_IN(ste_line), .STE_OUT(ste_drv), .STE_OE_OUT(ste_oe),
        .IRQ_OUT(irq));
    smcg_peer peer (.sclk_in(sclk), .sclk_oe_in(sclk_oe), .mosi_in(mosi),
        .mosi_oe_in(mosi_oe), .ste_drv_in(ste_drv), .ste_dir_in(ste_oe),
        .rival_in(rival), .miso_out(miso), .ste_line_out(ste_line),
        .rx_out(rx));
    // 100 MHz system clock
    initial begin
        forever #5 clk = !clk;
    end
    // Verdict and end of run, the single exit point
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard, well above the length of all tests
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    // Compare a 32-bit result
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;  // No answer counts as a mismatch
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Poll until shifter idle and no word pending
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, smcg_pkg::OFF_LIVE, 32'h0);
            n++;
        end while ((q & 32'h5) !== 32'h0 && n < 60);
    endtask
    // Load a word, let it go out, compare what the slave got
    task automatic send(input logic [7:0] d);
        apb(1'b1, smcg_pkg::OFF_TXBUF, {24'h0, d});
        wait_idle();
        chk("slave word", {24'h0, d}, {24'h0, rx});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, smcg_pkg::OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h1, q);
        apb(1'b0, smcg_pkg::OFF_MASK, 32'h0);
        chk("mask reset", 32'h0, q);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped data", 32'h0, q);
        chk("unmapped err", 32'h1, {31'h0, e});
        // Write during soft reset hold must be dropped
        apb(1'b1, smcg_pkg::OFF_TXBUF, 32'h11);
        apb(1'b0, smcg_pkg::OFF_LIVE, 32'h0);
        chk("held pending", 32'h0, q & 32'h4);
        $display("test reset done");
        // Guard mode, bus free: normal word plus interrupt paths
        apb(1'b1, smcg_pkg::OFF_CTRL, 32'hc);
        apb(1'b1, smcg_pkg::OFF_MASK, 32'h2);
        send(8'ha5);
        apb(1'b0, smcg_pkg::OFF_RXBUF, 32'h0);
        chk("rx byte", 32'hc3, q & 32'hff);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, smcg_pkg::OFF_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, smcg_pkg::OFF_MASK, 32'h2);
        apb(1'b1, smcg_pkg::OFF_STAT, 32'hf);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test guard transfer done");
        // Rival master takes the bus in mid-word
        apb(1'b1, smcg_pkg::OFF_TXBUF, 32'h3c);
        repeat (20) @(posedge clk);
        rival <= 1'b1;
        repeat (6) @(posedge clk);
        chk("sclk released", 32'h0, {31'h0, sclk_oe});
        chk("mosi released", 32'h0, {31'h0, mosi_oe});
        apb(1'b0, smcg_pkg::OFF_STAT, 32'h0);
        chk("abort flag", 32'h4, q & 32'h4);
        chk("tx without rx", 32'h2, q & 32'h3);
        apb(1'b1, smcg_pkg::OFF_STAT, 32'hf);
        rival <= 1'b0;
        wait_idle();
        chk("no auto resend", 32'h0, q & 32'h4);
        // Recovery pulse of the hold bit, then the word goes again
        apb(1'b1, smcg_pkg::OFF_CTRL, 32'hd);
        apb(1'b1, smcg_pkg::OFF_CTRL, 32'hc);
        send(8'h3c);
        $display("test abort done");
        // Load while the bus is held: flagged, data not compared
        rival <= 1'b1;
        apb(1'b1, smcg_pkg::OFF_TXBUF, 32'h77);
        apb(1'b0, smcg_pkg::OFF_STAT, 32'h0);
        chk("load inactive", 32'h8, q & 32'h8);
        rival <= 1'b0;
        wait_idle();
        apb(1'b1, smcg_pkg::OFF_STAT, 32'hf);
        $display("test inactive load done");
        // Direction select 1: pin driven as an output enable
        apb(1'b1, smcg_pkg::OFF_CTRL, 32'he);
        repeat (2) @(posedge clk);
        chk("ste driven", 32'h1, {31'h0, ste_oe});
        chk("ste idle", 32'h0, {31'h0, ste_drv});
        apb(1'b1, smcg_pkg::OFF_TXBUF, 32'h5a);
        repeat (4) @(posedge clk);
        chk("ste active", 32'h1, {31'h0, ste_drv});
        // Enable low holds the word; unfrozen it would end well before
        ce <= 1'b0;
        repeat (80) @(posedge clk);
        chk("ste frozen", 32'h1, {31'h0, ste_drv});
        ce <= 1'b1;
        wait_idle();
        chk("slave word oe", 32'h5a, {24'h0, rx});
        $display("test output enable done");
        wrap_up();
    end
endmodule

//--- logic/smcg_pkg.sv
// Constants shared by the conflict-guarded SPI master block
package smcg_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFF_CTRL = 8'h00;   // Control register
    localparam logic [7:0] OFF_TXBUF = 8'h04;  // Transmit buffer
    localparam logic [7:0] OFF_RXBUF = 8'h08;  // Receive buffer
    localparam logic [7:0] OFF_STAT = 8'h0c;   // Sticky event status
    localparam logic [7:0] OFF_MASK = 8'h10;   // Interrupt mask
    localparam logic [7:0] OFF_LIVE = 8'h14;   // Live state
    // Control bit positions
    localparam int CTRL_SWRST = 0;  // software_reset_hold
    localparam int CTRL_STEM = 1;   // enable_pin_direction_select
    localparam int CTRL_FOURPIN = 2;  // 4-pin mode enable
    localparam int CTRL_STE_POL = 3;  // Active level of enable pin
    // Status bit positions
    localparam int ST_RXF = 0;    // receive_full_flag
    localparam int ST_TXE = 1;    // transmit_empty_flag
    localparam int ST_ABORT = 2;  // Transfer aborted by enable pin
    localparam int ST_LOADBAD = 3;  // Buffer loaded while inactive
    // Reset values
    localparam logic [3:0] CTRL_RESET = 4'h1;  // Held in software reset
    localparam logic [3:0] MASK_RESET = 4'h0;
    // Serial clock half period in system cycles
    localparam logic [7:0] HALF_PERIOD_CYC = 8'h04;
    // Shifter states
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_LOW = 2'b01,
        SH_HIGH = 2'b10
    } smcg_state_t;
endpackage

//--- logic/smcg_top.sv
// SPI master with slave-enable pin conflict guard and APB registers
`timescale 1ns/1ns
// Behaviour
// - Direction select 0: enable pin is input.
// - Direction select 1 in 4-pin mode: drive enable pin out.
// - Load while inactive not guaranteed correct.
// - Direction select 0 in 4-pin mode: inactive enable aborts transfer; rewrite needed.
module smcg_top (
    // Clock, reset, enable
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // SPI pins
    output logic SCLK_OUT,
    output logic SCLK_OE_OUT,
    output logic MOSI_OUT,
    output logic MOSI_OE_OUT,
    input wire logic MISO_IN,
    input wire logic STE_IN,
    output logic STE_OUT,
    output logic STE_OE_OUT,
    // Interrupt
    output logic IRQ_OUT
);
    // Synchronisers for pin inputs
    logic [1:0] miso_s_q;
    logic [1:0] ste_s_q;
    // Control and status state
    logic [3:0] ctrl_q, ctrl_d;
    logic [3:0] stat_q, stat_d;
    logic [3:0] mask_q, mask_d;
    logic [7:0] txbuf_q, txbuf_d;   // transmit_buffer
    logic txfull_q, txfull_d;       // Word waiting in buffer
    logic txbad_q, txbad_d;         // Waiting word loaded while inactive
    logic [7:0] rxbuf_q, rxbuf_d;
    // Shifter state
    smcg_pkg::smcg_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic samp_q, samp_d;           // MISO bit caught at the rising clock
    logic [7:0] div_q, div_d;
    logic corrupt_q, corrupt_d;     // Word in shifter may be bad
    // Bus outputs
    logic [31:0] prdata_d;
    logic sclk_d, mosi_d, sclk_oe_d, mosi_oe_d, ste_d, ste_oe_d;

    // Decoded mode and pin state
    logic swrst, stem, fourpin, ste_active, guard_mode, bus_free;
    logic wr_en, rd_en, addr_ok;
    always_comb begin
        swrst = ctrl_q[smcg_pkg::CTRL_SWRST];
        stem = ctrl_q[smcg_pkg::CTRL_STEM];
        fourpin = ctrl_q[smcg_pkg::CTRL_FOURPIN];
        ste_active = (ste_s_q[1] == ctrl_q[smcg_pkg::CTRL_STE_POL]);
        guard_mode = fourpin && !stem;
        // Another master owns the bus when our input reads inactive
        bus_free = !guard_mode || ste_active;
        wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
        rd_en = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
        addr_ok = (PADDR_IN == smcg_pkg::OFF_CTRL)
            || (PADDR_IN == smcg_pkg::OFF_TXBUF)
            || (PADDR_IN == smcg_pkg::OFF_RXBUF)
            || (PADDR_IN == smcg_pkg::OFF_STAT)
            || (PADDR_IN == smcg_pkg::OFF_MASK)
            || (PADDR_IN == smcg_pkg::OFF_LIVE);
    end

    // Next-state logic for registers and shifter
    always_comb begin
        logic [3:0] ev;
        logic [3:0] clr;
        ev = 4'h0;
        clr = 4'h0;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        txbuf_d = txbuf_q;
        txfull_d = txfull_q;
        txbad_d = txbad_q;
        rxbuf_d = rxbuf_q;
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        div_d = div_q;
        corrupt_d = corrupt_q;
        samp_d = samp_q;
        // Register writes
        if (wr_en) begin
            unique case (PADDR_IN)
                smcg_pkg::OFF_CTRL: ctrl_d = PWDATA_IN[3:0];
                smcg_pkg::OFF_TXBUF: begin
                    if (!swrst) begin
                        txbuf_d = PWDATA_IN[7:0];
                        txfull_d = 1'b1;
                        // Loading while inactive is flagged, not fixed
                        txbad_d = !bus_free;
                        ev[smcg_pkg::ST_LOADBAD] = !bus_free;
                    end
                end
                smcg_pkg::OFF_STAT: clr = PWDATA_IN[3:0];
                smcg_pkg::OFF_MASK: mask_d = PWDATA_IN[3:0];
                default: ;
            endcase
        end
        // Shifter sequencing
        if (swrst) begin
            // Software reset hold clears the engine, keeps control
            st_d = smcg_pkg::SH_IDLE;
            txfull_d = 1'b0;
            txbad_d = 1'b0;
            bit_d = 3'h0;
            div_d = 8'h00;
        end else if (st_q != smcg_pkg::SH_IDLE && !bus_free) begin
            // Abort: word is dropped, software must rewrite it
            st_d = smcg_pkg::SH_IDLE;
            ev[smcg_pkg::ST_ABORT] = 1'b1;
            ev[smcg_pkg::ST_TXE] = 1'b1;
        end else begin
            unique case (st_q)
                smcg_pkg::SH_IDLE: begin
                    if (txfull_q && bus_free) begin
                        sh_d = txbuf_q;
                        corrupt_d = txbad_q;
                        txfull_d = 1'b0;
                        txbad_d = 1'b0;
                        ev[smcg_pkg::ST_TXE] = 1'b1;
                        bit_d = 3'h0;
                        div_d = 8'h00;
                        st_d = smcg_pkg::SH_LOW;
                    end
                end
                smcg_pkg::SH_LOW: begin
                    div_d = div_q + 8'h01;
                    if (div_q == smcg_pkg::HALF_PERIOD_CYC - 8'h01) begin
                        div_d = 8'h00;
                        // Catch MISO now, shift it in at the falling clock
                        samp_d = miso_s_q[1];
                        st_d = smcg_pkg::SH_HIGH;
                    end
                end
                smcg_pkg::SH_HIGH: begin
                    div_d = div_q + 8'h01;
                    if (div_q == smcg_pkg::HALF_PERIOD_CYC - 8'h01) begin
                        div_d = 8'h00;
                        // MOSI moves only here and at load, steady across the rise
                        sh_d = {sh_q[6:0], samp_q};
                        bit_d = bit_q + 3'h1;
                        st_d = smcg_pkg::SH_LOW;
                        if (bit_q == 3'h7) begin
                            rxbuf_d = {sh_q[6:0], samp_q};
                            ev[smcg_pkg::ST_RXF] = 1'b1;
                            st_d = smcg_pkg::SH_IDLE;
                        end
                    end
                end
                default: st_d = smcg_pkg::SH_IDLE;
            endcase
        end
        // Sticky status: set wins over clear
        stat_d = (stat_q & ~clr) | ev;
        // Reading the receive buffer drops its flag
        if (rd_en && PADDR_IN == smcg_pkg::OFF_RXBUF && !ev[0]) begin
            stat_d[smcg_pkg::ST_RXF] = 1'b0;
        end
    end

    // Pin and read-data next values
    always_comb begin
        // Released bus while another master is active
        sclk_oe_d = !swrst && bus_free;
        mosi_oe_d = !swrst && bus_free;
        sclk_d = (st_d == smcg_pkg::SH_HIGH);
        mosi_d = sh_d[7];
        // Enable pin driven only when direction select is 1
        ste_oe_d = fourpin && stem && !swrst;
        ste_d = (st_d != smcg_pkg::SH_IDLE)
            ? ctrl_q[smcg_pkg::CTRL_STE_POL]
            : !ctrl_q[smcg_pkg::CTRL_STE_POL];
        prdata_d = 32'h0;
        unique case (PADDR_IN)
            smcg_pkg::OFF_CTRL: prdata_d = {28'h0, ctrl_q};
            smcg_pkg::OFF_TXBUF: prdata_d = {24'h0, txbuf_q};
            smcg_pkg::OFF_RXBUF: prdata_d = {24'h0, rxbuf_q};
            smcg_pkg::OFF_STAT: prdata_d = {28'h0, stat_q};
            smcg_pkg::OFF_MASK: prdata_d = {28'h0, mask_q};
            smcg_pkg::OFF_LIVE: prdata_d = {28'h0, corrupt_q,
                txfull_q, ste_active, st_q != smcg_pkg::SH_IDLE};
            default: prdata_d = 32'h0;
        endcase
    end

    // Register all state
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            miso_s_q <= 2'h0;
            ste_s_q <= 2'h0;
            ctrl_q <= smcg_pkg::CTRL_RESET;
            stat_q <= 4'h0;
            mask_q <= smcg_pkg::MASK_RESET;
            txbuf_q <= 8'h00;
            txfull_q <= 1'b0;
            txbad_q <= 1'b0;
            rxbuf_q <= 8'h00;
            st_q <= smcg_pkg::SH_IDLE;
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            div_q <= 8'h00;
            corrupt_q <= 1'b0;
            samp_q <= 1'b0;
            PRDATA_OUT <= 32'h0;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            SCLK_OUT <= 1'b0;
            SCLK_OE_OUT <= 1'b0;
            MOSI_OUT <= 1'b0;
            MOSI_OE_OUT <= 1'b0;
            STE_OUT <= 1'b1;
            STE_OE_OUT <= 1'b0;
            IRQ_OUT <= 1'b0;
        end else if (CE_IN) begin
            miso_s_q <= {miso_s_q[0], MISO_IN};
            ste_s_q <= {ste_s_q[0], STE_IN};
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            txbuf_q <= txbuf_d;
            txfull_q <= txfull_d;
            txbad_q <= txbad_d;
            rxbuf_q <= rxbuf_d;
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            div_q <= div_d;
            corrupt_q <= corrupt_d;
            samp_q <= samp_d;
            // Read data captured in setup, ready one cycle later
            if (rd_en) begin
                PRDATA_OUT <= prdata_d;
            end
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !addr_ok;
            SCLK_OUT <= sclk_d;
            SCLK_OE_OUT <= sclk_oe_d;
            MOSI_OUT <= mosi_d;
            MOSI_OE_OUT <= mosi_oe_d;
            STE_OUT <= ste_d;
            STE_OE_OUT <= ste_oe_d;
            IRQ_OUT <= |(stat_d & mask_d);
        end
    end

    // Checks on the guard, enable pin, reset and interrupt behaviour
    sequence guard_lost_s;
        !swrst && guard_mode && !ste_active;
    endsequence
    sequence busy_s;
        st_q != smcg_pkg::SH_IDLE;
    endsequence

    abort_on_inactive_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CE_IN and busy_s and guard_lost_s |=> st_q == smcg_pkg::SH_IDLE
            && stat_q[smcg_pkg::ST_ABORT])
        else $error("transfer not aborted by inactive enable");
    release_bus_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CE_IN and guard_lost_s |=> !SCLK_OE_OUT && !MOSI_OE_OUT)
        else $error("bus not released while other master active");
    no_start_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CE_IN and guard_lost_s |=> st_q == smcg_pkg::SH_IDLE)
        else $error("transfer started while enable inactive");
    ste_input_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CE_IN && guard_mode |=> !STE_OE_OUT)
        else $error("enable pin driven in guard mode");
    ste_drive_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CE_IN && !swrst && fourpin && stem
            && st_d != smcg_pkg::SH_IDLE
            && !(wr_en && PADDR_IN == smcg_pkg::OFF_CTRL) |=>
            STE_OE_OUT && STE_OUT == ctrl_q[smcg_pkg::CTRL_STE_POL])
        else $error("enable output not asserted during transfer");
    load_flag_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (CE_IN && wr_en && PADDR_IN == smcg_pkg::OFF_TXBUF) and guard_lost_s
        |=> stat_q[smcg_pkg::ST_LOADBAD] && txbad_q)
        else $error("inactive load not flagged");
    swrst_idle_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CE_IN && swrst |=> st_q == smcg_pkg::SH_IDLE && !txfull_q)
        else $error("software reset did not clear engine");
    irq_level_a: assert property (
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        CE_IN |=> IRQ_OUT == |(stat_q & mask_q))
        else $error("interrupt level mismatch");
endmodule
